// *** include/tlpic_defs.svh ***
`ifndef TLPIC_DEFS_SVH
`define TLPIC_DEFS_SVH

// program counter width and vector addresses
`define TLPIC_PC_W 21
`define TLPIC_VEC_HIGH 21'h000008
`define TLPIC_VEC_LOW 21'h000018

// widest peripheral source group
`define TLPIC_PER_MAX 8

// register byte offsets on the slave bus
`define TLPIC_OFS_MAIN 5'h00
`define TLPIC_OFS_RCTL 5'h04
`define TLPIC_OFS_PFLAG 5'h08
`define TLPIC_OFS_PEN 5'h0C
`define TLPIC_OFS_PPRIO 5'h10
`define TLPIC_OFS_CPRIO 5'h14
`define TLPIC_OFS_STAT 5'h18

// interrupt_control_main field positions
`define TLPIC_B_GIE 7
`define TLPIC_B_PERIPHERAL_GROUP_ENABLE 6
`define TLPIC_B_T0IE 5
`define TLPIC_B_E0IE 4
`define TLPIC_B_PCIE 3
`define TLPIC_B_T0IF 2
`define TLPIC_B_E0IF 1
`define TLPIC_B_PCIF 0
// reset_control_reg field position
`define TLPIC_B_PRIORITY_MODE_ENABLE 7

// reset values
`define TLPIC_RST_MAIN 8'h00
`define TLPIC_RST_PFLAG 8'h00
`define TLPIC_RST_PEN 8'h00
`define TLPIC_RST_PPRIO 8'hFF
`define TLPIC_RST_CPRIO 2'h3

`endif

// *** include/tlpic_pkg.sv ***
`include "tlpic_defs.svh"

package tlpic_pkg;

  typedef enum logic {BUS_IDLE, BUS_DONE} tlpic_bus_type;

  typedef enum logic [2:0] {
    SEL_MAIN, SEL_RCTL, SEL_PFLAG, SEL_PEN, SEL_PPRIO, SEL_CPRIO, SEL_STAT, SEL_NONE
  } tlpic_sel_type;

  typedef struct packed {
    logic [4:0] address;
    logic [3:0] byteenable;
    logic read;
    logic write;
    logic [31:0] writedata;
  } tlpic_avreq_type;

  typedef struct packed {
    logic pcLoad;
    logic [`TLPIC_PC_W-1:0] pcAddr;
    logic stackPush;
    logic [`TLPIC_PC_W-1:0] pushData;
  } tlpic_core_type;

  typedef struct packed {
    logic [7:0] intMain;
    logic prioMode;
    logic [`TLPIC_PER_MAX-1:0] perFlag;
    logic [`TLPIC_PER_MAX-1:0] perEn;
    logic [`TLPIC_PER_MAX-1:0] perPrio;
    logic [1:0] corePrio;
    logic inHigh;
    logic inLow;
    logic [2:0] extPipe;
    tlpic_bus_type busPh;
    logic [31:0] rdData;
    tlpic_core_type core;
  } tlpic_state_type;

endpackage

// *** rtl/tlpic_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "tlpic_defs.svh"

module tlpic_ctrl #(
  parameter int NUM_PERIPH = `TLPIC_PER_MAX
) (
  input wire logic sys_clk, // instruction clock
  input wire logic resetn, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire tlpic_pkg::tlpic_avreq_type avsReq, // slave request
  output logic waitrequest, // slave stall
  output logic [31:0] readdata, // slave read data
  input wire logic timerZeroEvt, // timer 0 overflow pulse
  input wire logic extZeroPin, // external interrupt pin
  input wire logic portChangeEvt, // port mismatch level
  input wire logic [`TLPIC_PER_MAX-1:0] periphEvt, // peripheral events
  input wire logic [`TLPIC_PC_W-1:0] curPc, // return address
  input wire logic retIrq, // return_from_irq_instr executes
  output var tlpic_pkg::tlpic_core_type coreCtl, // pc load and push
  output logic inHighSvc, // high routine running
  output logic inLowSvc // low routine running
);
  import tlpic_pkg::*;

  if (NUM_PERIPH < 1 || NUM_PERIPH > `TLPIC_PER_MAX) begin : g_chk
    $error("NUM_PERIPH out of range");
  end

  localparam tlpic_state_type RST_STATE = '{
    intMain: `TLPIC_RST_MAIN,
    prioMode: 1'b0,
    perFlag: `TLPIC_RST_PFLAG,
    perEn: `TLPIC_RST_PEN,
    perPrio: `TLPIC_RST_PPRIO,
    corePrio: `TLPIC_RST_CPRIO,
    inHigh: 1'b0,
    inLow: 1'b0,
    extPipe: 3'h0,
    busPh: BUS_IDLE,
    rdData: 32'h0000_0000,
    core: '0
  };

  tlpic_state_type s_r;
  tlpic_state_type s_nxt;

  function automatic tlpic_sel_type regSel(input logic [4:0] a);
    logic [4:0] w;
    w = {a[4:2], 2'b00};
    case (w)
      `TLPIC_OFS_MAIN: regSel = SEL_MAIN;
      `TLPIC_OFS_RCTL: regSel = SEL_RCTL;
      `TLPIC_OFS_PFLAG: regSel = SEL_PFLAG;
      `TLPIC_OFS_PEN: regSel = SEL_PEN;
      `TLPIC_OFS_PPRIO: regSel = SEL_PPRIO;
      `TLPIC_OFS_CPRIO: regSel = SEL_CPRIO;
      `TLPIC_OFS_STAT: regSel = SEL_STAT;
      default: regSel = SEL_NONE;
    endcase
  endfunction

  logic [`TLPIC_PER_MAX-1:0] perReq;
  logic [`TLPIC_PER_MAX-1:0] perSet;
  logic [2:0] coreReq;
  logic [2:0] coreIsHi;
  logic extEdge;
  logic hiAny;
  logic loAny;
  logic compAny;
  logic takeHi;
  logic takeLo;
  logic [31:0] readMux;
  logic busReq;

  // sources beyond NUM_PERIPH never request, and their events never set a flag
  for (genvar i = 0; i < `TLPIC_PER_MAX; i++) begin : g_per
    if (i < NUM_PERIPH) begin : g_on
      assign perReq[i] = s_r.perFlag[i] & s_r.perEn[i];
      assign perSet[i] = periphEvt[i];
    end else begin : g_off
      assign perReq[i] = 1'b0;
      assign perSet[i] = 1'b0;
    end
  end

  // second and third pipe stages only: the first stage is a bare synchroniser
  assign extEdge = s_r.extPipe[1] & ~s_r.extPipe[2];

  assign coreReq = {
    s_r.intMain[`TLPIC_B_T0IF] & s_r.intMain[`TLPIC_B_T0IE],
    s_r.intMain[`TLPIC_B_E0IF] & s_r.intMain[`TLPIC_B_E0IE],
    s_r.intMain[`TLPIC_B_PCIF] & s_r.intMain[`TLPIC_B_PCIE]
  };
  // external 0 has no priority bit: always high level
  assign coreIsHi = {s_r.corePrio[1], 1'b1, s_r.corePrio[0]};

  assign hiAny = (|(coreReq & coreIsHi)) | (|(perReq & s_r.perPrio));
  assign loAny = (|(coreReq & ~coreIsHi)) | (|(perReq & ~s_r.perPrio));
  assign compAny = (|coreReq) | ((|perReq) & s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE]);

  // a return in flight wins the cycle; the request is taken one cycle later
  always_comb begin
    if (s_r.prioMode) begin
      takeHi = !retIrq && hiAny && s_r.intMain[`TLPIC_B_GIE];
    end else begin
      takeHi = !retIrq && compAny && s_r.intMain[`TLPIC_B_GIE];
    end
  end

  // low waits for any high routine and loses a tie
  assign takeLo = !retIrq && s_r.prioMode && loAny && s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE]
    && !s_r.inHigh && !takeHi;

  always_comb begin
    readMux = 32'h0000_0000;
    case (regSel(avsReq.address))
      SEL_MAIN: readMux[7:0] = s_r.intMain;
      SEL_RCTL: readMux[`TLPIC_B_PRIORITY_MODE_ENABLE] = s_r.prioMode;
      SEL_PFLAG: readMux[`TLPIC_PER_MAX-1:0] = s_r.perFlag;
      SEL_PEN: readMux[`TLPIC_PER_MAX-1:0] = s_r.perEn;
      SEL_PPRIO: readMux[`TLPIC_PER_MAX-1:0] = s_r.perPrio;
      SEL_CPRIO: readMux[1:0] = s_r.corePrio;
      SEL_STAT: readMux[1:0] = {s_r.inLow, s_r.inHigh};
      default: readMux = 32'h0000_0000;
    endcase
  end

  // either strobe opens an access; the master never raises both
  assign busReq = avsReq.read | avsReq.write;

  always_comb begin
    s_nxt = s_r;
    s_nxt.core.pcLoad = 1'b0;
    s_nxt.core.stackPush = 1'b0;
    s_nxt.extPipe = {s_r.extPipe[1:0], extZeroPin};

    // one wait state; write lands at the edge waitrequest is low
    case (s_r.busPh)
      BUS_IDLE: begin
        if (busReq) begin
          s_nxt.busPh = BUS_DONE;
          s_nxt.rdData = avsReq.read ? readMux : 32'h0000_0000;
        end
      end
      BUS_DONE: begin
        s_nxt.busPh = BUS_IDLE;
        if (avsReq.write && avsReq.byteenable[0]) begin
          case (regSel(avsReq.address))
            SEL_MAIN: s_nxt.intMain = avsReq.writedata[7:0];
            SEL_RCTL: s_nxt.prioMode = avsReq.writedata[`TLPIC_B_PRIORITY_MODE_ENABLE];
            SEL_PFLAG: s_nxt.perFlag = avsReq.writedata[`TLPIC_PER_MAX-1:0];
            SEL_PEN: s_nxt.perEn = avsReq.writedata[`TLPIC_PER_MAX-1:0];
            SEL_PPRIO: s_nxt.perPrio = avsReq.writedata[`TLPIC_PER_MAX-1:0];
            SEL_CPRIO: s_nxt.corePrio = avsReq.writedata[1:0];
            default: s_nxt.busPh = BUS_IDLE;
          endcase
        end
      end
      default: s_nxt.busPh = BUS_IDLE;
    endcase

    // events after the bus write: a set in the clearing cycle survives
    if (timerZeroEvt) begin
      s_nxt.intMain[`TLPIC_B_T0IF] = 1'b1;
    end
    if (extEdge) begin
      s_nxt.intMain[`TLPIC_B_E0IF] = 1'b1;
    end
    if (portChangeEvt) begin
      s_nxt.intMain[`TLPIC_B_PCIF] = 1'b1;
    end
    s_nxt.perFlag = s_nxt.perFlag | perSet;

    // hardware enable updates override a same-cycle software write
    if (takeHi || takeLo) begin
      s_nxt.core.pcLoad = 1'b1;
      s_nxt.core.stackPush = 1'b1;
      s_nxt.core.pushData = curPc;
      s_nxt.core.pcAddr = takeLo ? `TLPIC_VEC_LOW : `TLPIC_VEC_HIGH;
    end
    if (takeHi) begin
      s_nxt.intMain[`TLPIC_B_GIE] = 1'b0;
      s_nxt.inHigh = 1'b1;
    end
    if (takeLo) begin
      s_nxt.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE] = 1'b0;
      s_nxt.inLow = 1'b1;
    end

    // return closes the innermost routine
    if (retIrq) begin
      if (!s_r.prioMode || s_r.inHigh || !s_r.inLow) begin
        s_nxt.intMain[`TLPIC_B_GIE] = 1'b1;
        s_nxt.inHigh = 1'b0;
        if (!s_r.prioMode) begin
          s_nxt.inLow = 1'b0;
        end
      end else begin
        s_nxt.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE] = 1'b1;
        s_nxt.inLow = 1'b0;
      end
    end
  end

  // clkEn low freezes every bit, so an event pulse in a frozen cycle is dropped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= RST_STATE;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  // one wait state per access, longer while clkEn is low
  assign waitrequest = busReq && (s_r.busPh == BUS_IDLE);
  assign readdata = s_r.rdData;
  assign coreCtl = s_r.core;
  assign inHighSvc = s_r.inHigh;
  assign inLowSvc = s_r.inLow;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // most checks look at the registered outputs, so a broken take term shows up

  a_vector_range: assert property (
    coreCtl.pcLoad |-> (coreCtl.pcAddr == `TLPIC_VEC_HIGH
      || coreCtl.pcAddr == `TLPIC_VEC_LOW))
    else $error("vector address is neither high nor low");

  a_prio_vector_sel: assert property (
    clkEn && s_r.prioMode && takeLo |=> coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_LOW)
    else $error("low request did not vector low");

  a_compat_vector: assert property (
    clkEn && !s_r.prioMode && (takeHi || takeLo) |=>
      coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_HIGH)
    else $error("compatibility vector is not high");

  a_enable_cleared: assert property (
    clkEn && takeHi |=> !s_r.intMain[`TLPIC_B_GIE] && s_r.inHigh)
    else $error("global enable not cleared on accept");

  a_no_low_in_high: assert property (
    s_r.inHigh |=> !(coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_LOW))
    else $error("low taken during high routine");

  a_high_wins_tie: assert property (
    clkEn && s_r.prioMode && hiAny && loAny && s_r.intMain[`TLPIC_B_GIE] && !retIrq
      |=> coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_HIGH)
    else $error("tie not resolved to high");

  a_push_return: assert property (
    clkEn && (takeHi || takeLo) |=> coreCtl.stackPush && coreCtl.pushData == $past(curPc))
    else $error("return address not pushed");

  a_return_restore: assert property (
    clkEn && retIrq && !s_r.prioMode |=> s_r.intMain[`TLPIC_B_GIE] && !s_r.inHigh)
    else $error("return did not restore global enable");

  a_flag_polling: assert property (
    clkEn && timerZeroEvt |=> s_r.intMain[`TLPIC_B_T0IF])
    else $error("timer flag not set by event");

  a_ext_latency: assert property (
    clkEn [*3] ##0 $rose(s_r.extPipe[1]) && !s_r.extPipe[2] |=> s_r.intMain[`TLPIC_B_E0IF])
    else $error("external flag late");

  a_low_enable_cleared: assert property (
    clkEn && takeLo |=> !s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE] && s_r.inLow)
    else $error("low enable not cleared on accept");

  a_prio_ret_high: assert property (
    clkEn && retIrq && s_r.prioMode && s_r.inHigh |=> s_r.intMain[`TLPIC_B_GIE] && !s_r.inHigh)
    else $error("return did not restore high enable");

  a_prio_ret_low: assert property (
    clkEn && retIrq && s_r.prioMode && !s_r.inHigh && s_r.inLow
      |=> s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE] && !s_r.inLow)
    else $error("return did not restore low enable");

  a_port_flag: assert property (
    clkEn && portChangeEvt |=> s_r.intMain[`TLPIC_B_PCIF])
    else $error("port change flag not set by event");

  a_periph_flag: assert property (
    clkEn && periphEvt[0] |=> s_r.perFlag[0])
    else $error("peripheral flag not set by event");

  a_ret_blocks_take: assert property (
    clkEn && retIrq |=> !coreCtl.pcLoad)
    else $error("vector taken in a return cycle");

  a_high_gate_closed: assert property (
    clkEn && s_r.prioMode && !s_r.intMain[`TLPIC_B_GIE]
      |=> !(coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_HIGH))
    else $error("high vector with high enable clear");

  a_low_gate_closed: assert property (
    clkEn && s_r.prioMode && !s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE]
      |=> !(coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_LOW))
    else $error("low vector with low enable clear");

  a_compat_all_off: assert property (
    clkEn && !s_r.prioMode && !s_r.intMain[`TLPIC_B_GIE] |=> !coreCtl.pcLoad)
    else $error("vector with global enable clear");

  a_compat_periph_gate: assert property (
    clkEn && !s_r.prioMode && !s_r.intMain[`TLPIC_B_PERIPHERAL_GROUP_ENABLE] && !(|coreReq)
      |=> !coreCtl.pcLoad)
    else $error("peripheral vector with group enable clear");

  a_push_with_load: assert property (
    coreCtl.pcLoad |-> coreCtl.stackPush)
    else $error("vector without stack push");

  a_high_vector: assert property (
    clkEn && takeHi |=> coreCtl.pcLoad && coreCtl.pcAddr == `TLPIC_VEC_HIGH)
    else $error("high request did not vector high");

endmodule // tlpic_ctrl

`default_nettype wire

// *** verification/tlpic_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "tlpic_defs.svh"

// core side: program counter, return stack and return instruction
module tlpic_core_model (
  input wire logic sys_clk, // instruction clock
  input wire logic resetn, // async reset, active low
  input wire tlpic_pkg::tlpic_core_type coreCtl, // vector and push
  input wire logic retReq, // bench asks for a return
  output logic [`TLPIC_PC_W-1:0] curPc, // running pc
  output logic [`TLPIC_PC_W-1:0] prevPc, // pc one cycle ago
  output logic retIrq // return_from_irq_instr
);
  import tlpic_pkg::*;
  logic [`TLPIC_PC_W-1:0] stack [0:7];
  logic [2:0] sp;

  // a return with an empty stack is never issued
  assign retIrq = retReq && (sp != 3'h0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      curPc <= 21'h000100;
      prevPc <= 21'h000000;
      sp <= 3'h0;
    end else begin
      prevPc <= curPc;
      if (coreCtl.pcLoad) begin
        stack[sp] <= coreCtl.pushData;
        sp <= sp + 3'h1;
        curPc <= coreCtl.pcAddr;
      end else if (retIrq) begin
        curPc <= stack[sp-3'h1];
        sp <= sp - 3'h1;
      end else begin
        curPc <= curPc + 21'h000002;
      end
    end
  end
endmodule // tlpic_core_model

`default_nettype wire

// *** verification/tlpic_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "tlpic_defs.svh"

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, e); end end

module tlpic_ctrl_tb_top;
  import tlpic_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  tlpic_avreq_type avsReq = '0;
  logic waitrequest;
  logic [31:0] readdata;
  logic timerZeroEvt = 1'b0;
  logic extZeroPin = 1'b0;
  logic portChangeEvt = 1'b0;
  logic [`TLPIC_PER_MAX-1:0] periphEvt = '0;
  logic [`TLPIC_PC_W-1:0] curPc;
  logic [`TLPIC_PC_W-1:0] prevPc;
  logic retIrq;
  logic retReq = 1'b0;
  tlpic_core_type coreCtl;
  logic inHighSvc;
  logic inLowSvc;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int lat;

  always #4 sys_clk = ~sys_clk;

  tlpic_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .avsReq(avsReq),
    .waitrequest(waitrequest), .readdata(readdata), .timerZeroEvt(timerZeroEvt),
    .extZeroPin(extZeroPin), .portChangeEvt(portChangeEvt), .periphEvt(periphEvt),
    .curPc(curPc), .retIrq(retIrq), .coreCtl(coreCtl), .inHighSvc(inHighSvc),
    .inLowSvc(inLowSvc));

  tlpic_core_model u_core (.sys_clk(sys_clk), .resetn(resetn), .coreCtl(coreCtl),
    .retReq(retReq), .curPc(curPc), .prevPc(prevPc), .retIrq(retIrq));

  task automatic complete_run;
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // single-register accesses only, never a memory-to-memory move
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avsReq.address <= a;
    avsReq.byteenable <= 4'hF;
    avsReq.write <= wr;
    avsReq.read <= ~wr;
    avsReq.writedata <= {24'h000000, d};
    @(posedge sys_clk);
    while (waitrequest !== 1'b0) @(posedge sys_clk);
    avsReq.write <= 1'b0;
    avsReq.read <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(readdata, {24'h000000, e})
  endtask

  // waits for the vector pulse, then checks address and pushed return pc
  task automatic take(input logic [`TLPIC_PC_W-1:0] v);
    lat = 0;
    do begin
      @(posedge sys_clk);
      lat++;
    end while (coreCtl.pcLoad !== 1'b1 && lat < 50);
    `CHK(coreCtl.pcLoad, 1'b1)
    `CHK(coreCtl.stackPush, 1'b1)
    `CHK(coreCtl.pcAddr, v)
    `CHK(coreCtl.pushData, prevPc)
  endtask

  task automatic ret;
    @(posedge sys_clk) retReq <= 1'b1;
    @(posedge sys_clk) retReq <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`TLPIC_OFS_MAIN, 8'h00);
    rd(`TLPIC_OFS_RCTL, 8'h00);
    rd(`TLPIC_OFS_PPRIO, 8'hFF);
    rd(`TLPIC_OFS_CPRIO, 8'h03);
    rd(5'h1C, 8'h00);
    // compatibility mode, flags raised with global enable clear, then enabled
    bus(1'b1, `TLPIC_OFS_MAIN, 8'h20);
    @(posedge sys_clk) timerZeroEvt <= 1'b1;
    portChangeEvt <= 1'b1;
    @(posedge sys_clk) timerZeroEvt <= 1'b0;
    portChangeEvt <= 1'b0;
    rd(`TLPIC_OFS_MAIN, 8'h25);
    `CHK(inHighSvc, 1'b0)
    bus(1'b1, `TLPIC_OFS_MAIN, 8'hA4);
    take(`TLPIC_VEC_HIGH);
    rd(`TLPIC_OFS_MAIN, 8'h24);
    bus(1'b1, `TLPIC_OFS_MAIN, 8'h20);
    ret();
    rd(`TLPIC_OFS_MAIN, 8'hA0);
    `CHK(inHighSvc, 1'b0)
    // priority mode: low peripheral, then high external preempts it
    bus(1'b1, `TLPIC_OFS_RCTL, 8'h80);
    bus(1'b1, `TLPIC_OFS_PPRIO, 8'hFE);
    bus(1'b1, `TLPIC_OFS_PEN, 8'h01);
    bus(1'b1, `TLPIC_OFS_MAIN, 8'h40);
    @(posedge sys_clk) periphEvt <= 8'h01;
    @(posedge sys_clk) periphEvt <= 8'h00;
    take(`TLPIC_VEC_LOW);
    `CHK(inLowSvc, 1'b1)
    rd(`TLPIC_OFS_MAIN, 8'h00);
    bus(1'b1, `TLPIC_OFS_MAIN, 8'h90);
    @(posedge sys_clk) extZeroPin <= 1'b1;
    take(`TLPIC_VEC_HIGH);
    `CHK((lat >= 4 && lat <= 5), 1'b1)
    `CHK(inHighSvc, 1'b1)
    rd(`TLPIC_OFS_STAT, 8'h03);
    // low request stays pending while the high routine runs
    bus(1'b1, `TLPIC_OFS_MAIN, 8'h50);
    extZeroPin <= 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      `CHK(coreCtl.pcLoad, 1'b0)
    end
    ret();
    take(`TLPIC_VEC_LOW);
    `CHK(inHighSvc, 1'b0)
    // clock enable low: an event in the frozen cycle is lost
    clkEn <= 1'b0;
    timerZeroEvt <= 1'b1;
    @(posedge sys_clk) timerZeroEvt <= 1'b0;
    clkEn <= 1'b1;
    rd(`TLPIC_OFS_MAIN, 8'h90);
    rd(`TLPIC_OFS_STAT, 8'h02);
    rd(`TLPIC_OFS_PFLAG, 8'h01);
    complete_run();
  end
endmodule // tlpic_ctrl_tb_top

`default_nettype wire
